// [rtl/omu_defs.svh]
// Register offsets, field positions, reset values and timing figures.
`ifndef OMU_DEFS_SVH
`define OMU_DEFS_SVH

`define OMU_A_VAL_FIRST 16'ha060
`define OMU_A_VAL_LAST  16'ha06d
`define OMU_A_CAP       16'ha06f
`define OMU_A_TXALM     16'ha070
`define OMU_A_RXALM     16'ha071
`define OMU_A_TXWRN     16'ha074
`define OMU_A_RXWRN     16'ha075
`define OMU_A_CTRL      16'ha100

`define OMU_CAP_TEMP  7
`define OMU_CAP_BIAS  6
`define OMU_CAP_TXPWR 5
`define OMU_CAP_RXPWR 4
`define OMU_CAP_ALARM 3
`define OMU_CAP_WARN  2
`define OMU_CAP_LINK  1

`define OMU_STAT_MSB 3
`define OMU_STAT_LSB 2
`define OMU_CMD_MSB  1
`define OMU_CMD_LSB  0

`define OMU_CMD_RST  2'h0
`define OMU_FLAG_RST 16'h0000

`define OMU_CLK_MHZ  50
`define OMU_SLOW_MS  1000
`define OMU_MID_MS   100
`define OMU_FAST_MS  10
`define OMU_TMO_MS   1

`endif

// [rtl/omu_pkg.sv]
// Types shared by the optical monitor update control block.
package omu_pkg;

	typedef enum logic [1:0] {
		OMU_S_IDLE = 2'h0,
		OMU_S_OK   = 2'h1,
		OMU_S_BUSY = 2'h2,
		OMU_S_FAIL = 2'h3
	} omu_status_t;

	typedef enum logic [1:0] {
		OMU_ST_IDLE = 2'b01,
		OMU_ST_WAIT = 2'b10
	} omu_state_t;

	typedef logic [3:0][15:0] omu_quad_t;

endpackage : omu_pkg

// [rtl/omu_top.sv]
// Optical monitor update control, capability and flag registers.
`timescale 1ns/1ps
`include "omu_defs.svh"

module omu_top #(
	parameter bit CAP_TEMP  = 1'b1,
	parameter bit CAP_BIAS  = 1'b1,
	parameter bit CAP_TXPWR = 1'b1,
	parameter bit CAP_RXPWR = 1'b1,
	parameter bit CAP_ALARM = 1'b1,
	parameter bit CAP_WARN  = 1'b1,
	parameter bit CAP_LINK  = 1'b1,
	parameter int SLOW_CYC  = `OMU_SLOW_MS * 1000 * `OMU_CLK_MHZ,
	parameter int MID_CYC   = `OMU_MID_MS * 1000 * `OMU_CLK_MHZ,
	parameter int FAST_CYC  = `OMU_FAST_MS * 1000 * `OMU_CLK_MHZ,
	parameter int TMO_CYC   = `OMU_TMO_MS * 1000 * `OMU_CLK_MHZ
) (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               reset_n,
	// Management register access
	input  wire logic               mgmt_wr,
	input  wire logic               mgmt_rd,
	input  wire logic [15:0]        mgmt_addr,
	input  wire logic [15:0]        mgmt_wdata,
	output logic      [15:0]        mgmt_rdata,
	output logic                    mgmt_rdata_valid,
	// Converter sample handshake
	output logic                    sample_req,
	input  wire logic               sample_done,
	input  wire logic               sample_error,
	input  wire omu_pkg::omu_quad_t adc_value,
	// Thresholds
	input  wire omu_pkg::omu_quad_t alarm_hi_thr,
	input  wire omu_pkg::omu_quad_t alarm_lo_thr,
	input  wire omu_pkg::omu_quad_t warn_hi_thr,
	input  wire omu_pkg::omu_quad_t warn_lo_thr,
	// Flags toward the link alarm logic
	output logic      [15:0]        alarm_flags,
	output logic      [15:0]        warn_flags,
	output logic      [15:0]        link_alarm_interrupt_flags
);

	// Temperature is two's complement; the other quantities are unsigned.
	function automatic logic omu_above(input logic [15:0] a,
		input logic [15:0] b, input logic is_signed);
		omu_above = is_signed ? ($signed(a) > $signed(b)) : (a > b);
	endfunction : omu_above

	// Upper byte is the transmit flag register, lower the receive one.
	function automatic logic [15:0] omu_flags(input omu_pkg::omu_quad_t v,
		input omu_pkg::omu_quad_t hi, input omu_pkg::omu_quad_t lo);
		logic [3:0] h;
		logic [3:0] l;
		h = '0;
		l = '0;
		for (int q = 0; q < 4; q++) begin
			h[q] = omu_above(v[q], hi[q], q == 0);
			l[q] = omu_above(lo[q], v[q], q == 0);
		end
		omu_flags = {h[0], l[0], 2'b00, h[1], l[1], h[2], l[2],
			h[3], l[3], 6'b00_0000};
	endfunction : omu_flags

	logic [7:0]          cap_word;
	logic                alm_on;
	omu_pkg::omu_state_t state;
	omu_pkg::omu_state_t next_state;
	omu_pkg::omu_status_t status;
	omu_pkg::omu_status_t next_status;
	logic [1:0]          cmd;
	logic [1:0]          next_cmd;
	logic                periodic;
	logic                next_periodic;
	logic                pending;
	logic                next_pending;
	logic [31:0]         timer;
	logic [31:0]         next_timer;
	logic                next_sample_req;
	omu_pkg::omu_quad_t  mon;
	omu_pkg::omu_quad_t  next_mon;
	logic [15:0]         prev_alm;
	logic [15:0]         next_prev_alm;
	logic [15:0]         prev_wrn;
	logic [15:0]         next_prev_wrn;
	logic [15:0]         next_alarm_flags;
	logic [15:0]         next_warn_flags;
	logic [15:0]         next_link_flags;
	logic [15:0]         next_rdata;
	logic [31:0]         interval;
	logic [15:0]         cond_alm;
	logic [15:0]         cond_wrn;
	logic [15:0]         val_idx;
	logic                wr_ctrl;
	logic                refresh_ok;

	assign cap_word[`OMU_CAP_TEMP]  = CAP_TEMP;
	assign cap_word[`OMU_CAP_BIAS]  = CAP_BIAS;
	assign cap_word[`OMU_CAP_TXPWR] = CAP_TXPWR;
	assign cap_word[`OMU_CAP_RXPWR] = CAP_RXPWR;
	assign alm_on = CAP_ALARM | CAP_LINK;
	assign cap_word[`OMU_CAP_ALARM] = alm_on;
	assign cap_word[`OMU_CAP_WARN]  = CAP_WARN;
	assign cap_word[`OMU_CAP_LINK]  = CAP_LINK;
	assign cap_word[0]              = 1'b0;

	assign wr_ctrl    = mgmt_wr && (mgmt_addr == `OMU_A_CTRL);
	assign refresh_ok = (state == omu_pkg::OMU_ST_WAIT) && sample_done
		&& !sample_error;
	assign val_idx    = mgmt_addr - `OMU_A_VAL_FIRST;

	assign cond_alm = alm_on ? omu_flags(adc_value, alarm_hi_thr,
		alarm_lo_thr) : '0;
	assign cond_wrn = CAP_WARN ? omu_flags(adc_value, warn_hi_thr,
		warn_lo_thr) : '0;

	always_comb begin
		unique case (cmd)
			2'h1:    interval = 32'(SLOW_CYC - 1);
			2'h2:    interval = 32'(MID_CYC - 1);
			default: interval = 32'(FAST_CYC - 1);
		endcase
	end

	always_comb begin
		next_state       = state;
		next_status      = status;
		next_cmd         = cmd;
		next_periodic    = periodic;
		next_pending     = pending;
		next_timer       = timer;
		next_sample_req  = 1'b0;
		next_mon         = mon;
		next_prev_alm    = prev_alm;
		next_prev_wrn    = prev_wrn;
		next_alarm_flags = alarm_flags;
		next_warn_flags  = warn_flags;
		unique case (state)
			omu_pkg::OMU_ST_IDLE: begin
				if (pending) begin
					next_state      = omu_pkg::OMU_ST_WAIT;
					next_status     = omu_pkg::OMU_S_BUSY;
					next_sample_req = 1'b1;
					next_pending    = 1'b0;
					next_timer      = '0;
				end else if (periodic) begin
					if (timer >= interval) begin
						next_pending = 1'b1;
						next_timer   = '0;
					end else begin
						next_timer = timer + 32'h1;
					end
				end
			end
			omu_pkg::OMU_ST_WAIT: begin
				next_timer = timer + 32'h1;
				if (sample_done && !sample_error) begin
					next_state    = omu_pkg::OMU_ST_IDLE;
					next_status   = omu_pkg::OMU_S_OK;
					next_timer    = '0;
					next_mon      = adc_value;
					next_prev_alm = cond_alm;
					next_prev_wrn = cond_wrn;
					next_alarm_flags = cond_alm & prev_alm;
					next_warn_flags  = cond_wrn & prev_wrn;
				end else if (sample_done || timer >= 32'(TMO_CYC - 1)) begin
					next_state    = omu_pkg::OMU_ST_IDLE;
					next_status   = omu_pkg::OMU_S_FAIL;
					next_periodic = 1'b0;
					next_timer    = '0;
				end
			end
		endcase
		if (wr_ctrl) begin
			next_cmd     = mgmt_wdata[`OMU_CMD_MSB:`OMU_CMD_LSB];
			next_pending = 1'b1;
			if (state == omu_pkg::OMU_ST_IDLE) begin
				next_timer = '0;
			end
			next_periodic = (mgmt_wdata[`OMU_CMD_MSB:`OMU_CMD_LSB] != 2'h0);
		end
		next_link_flags = CAP_LINK ? next_alarm_flags : '0;
	end

	// Unmapped or reserved addresses read as zero.
	always_comb begin
		next_rdata = '0;
		if (mgmt_addr >= `OMU_A_VAL_FIRST &&
			mgmt_addr <= `OMU_A_VAL_LAST) begin
			unique case (val_idx[3:1])
				3'h0:    next_rdata[7:0] = val_idx[0] ? mon[0][7:0]
					: mon[0][15:8];
				3'h2:    next_rdata[7:0] = val_idx[0] ? mon[1][7:0]
					: mon[1][15:8];
				3'h3:    next_rdata[7:0] = val_idx[0] ? mon[2][7:0]
					: mon[2][15:8];
				3'h4:    next_rdata[7:0] = val_idx[0] ? mon[3][7:0]
					: mon[3][15:8];
				default: next_rdata = '0;
			endcase
		end else begin
			unique case (mgmt_addr)
				`OMU_A_CAP:   next_rdata[7:0] = cap_word;
				`OMU_A_TXALM: next_rdata[7:0] = alarm_flags[15:8];
				`OMU_A_RXALM: next_rdata[7:0] = alarm_flags[7:0];
				`OMU_A_TXWRN: next_rdata[7:0] = warn_flags[15:8];
				`OMU_A_RXWRN: next_rdata[7:0] = warn_flags[7:0];
				`OMU_A_CTRL: begin
					next_rdata[`OMU_STAT_MSB:`OMU_STAT_LSB] = status;
					next_rdata[`OMU_CMD_MSB:`OMU_CMD_LSB]   = cmd;
				end
				default:      next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state            <= omu_pkg::OMU_ST_IDLE;
			status           <= omu_pkg::OMU_S_IDLE;
			cmd              <= `OMU_CMD_RST;
			periodic         <= 1'b0;
			pending          <= 1'b0;
			timer            <= '0;
			sample_req       <= 1'b0;
			mon              <= '0;
			prev_alm         <= `OMU_FLAG_RST;
			prev_wrn         <= `OMU_FLAG_RST;
			alarm_flags      <= `OMU_FLAG_RST;
			warn_flags       <= `OMU_FLAG_RST;
			link_alarm_interrupt_flags <= `OMU_FLAG_RST;
			mgmt_rdata       <= '0;
			mgmt_rdata_valid <= 1'b0;
		end else begin
			state            <= next_state;
			status           <= next_status;
			cmd              <= next_cmd;
			periodic         <= next_periodic;
			pending          <= next_pending;
			timer            <= next_timer;
			sample_req       <= next_sample_req;
			mon              <= next_mon;
			prev_alm         <= next_prev_alm;
			prev_wrn         <= next_prev_wrn;
			alarm_flags      <= next_alarm_flags;
			warn_flags       <= next_warn_flags;
			link_alarm_interrupt_flags <= next_link_flags;
			mgmt_rdata       <= mgmt_rd ? next_rdata : mgmt_rdata;
			mgmt_rdata_valid <= mgmt_rd;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_cap_link_alarm:
		assert property (cap_word[`OMU_CAP_LINK] |->
			cap_word[`OMU_CAP_ALARM])
		else $error("link feed set without alarm support");
	a_cap_read_word:
		assert property (mgmt_rd && mgmt_addr == `OMU_A_CAP |=>
			mgmt_rdata_valid && mgmt_rdata == {8'h00, cap_word})
		else $error("capability read wrong");
	a_busy_in_wait:
		assert property (state == omu_pkg::OMU_ST_WAIT |->
			status == omu_pkg::OMU_S_BUSY)
		else $error("status not busy during refresh");
	a_ok_after_done:
		assert property (refresh_ok |=> status == omu_pkg::OMU_S_OK
			&& state == omu_pkg::OMU_ST_IDLE)
		else $error("good refresh did not show success");
	a_fail_stops_periodic:
		assert property (state == omu_pkg::OMU_ST_WAIT && sample_done
			&& sample_error && !wr_ctrl |=>
			status == omu_pkg::OMU_S_FAIL && !periodic)
		else $error("failed refresh left periodic running");
	a_single_cmd_stop:
		assert property (wr_ctrl && mgmt_wdata[1:0] == 2'h0 |=>
			!periodic && pending)
		else $error("single command did not stop periodic");
	a_periodic_cmd_start:
		assert property (wr_ctrl && mgmt_wdata[1:0] != 2'h0 |=>
			periodic && cmd == $past(mgmt_wdata[1:0]))
		else $error("periodic command not taken");
	a_pending_launches:
		assert property (state == omu_pkg::OMU_ST_IDLE && pending |=>
			state == omu_pkg::OMU_ST_WAIT && sample_req)
		else $error("pending refresh not launched");
	a_flags_only_refresh:
		assert property (!refresh_ok |=> $stable(alarm_flags)
			&& $stable(warn_flags))
		else $error("flags changed outside a refresh");
	a_status_readback:
		assert property (mgmt_rd && mgmt_addr == `OMU_A_CTRL |=>
			mgmt_rdata[3:2] == $past(status) && mgmt_rdata[15:4] == '0)
		else $error("status readback wrong");

endmodule : omu_top

// [testbench/omu_adc_model.sv]
// Behavioural converter that answers sample requests after a set delay.
`timescale 1ns/1ps

module omu_adc_model (
	// Clock and reset
	input  wire logic          ref_clk,
	input  wire logic          reset_n,
	// Request and scenario controls
	input  wire logic          sample_req,
	input  wire logic          fail,
	input  wire logic [3:0]    lat,
	// Answer
	output logic               sample_done,
	output logic               sample_error,
	output omu_pkg::omu_quad_t adc_value
);
	// Receive 5, transmit 50, bias 300, temperature minus 5.
	localparam omu_pkg::omu_quad_t VAL =
		{16'h0005, 16'h0032, 16'h012c, 16'hfffb};
	logic       busy;
	logic [3:0] cnt;
	// Between answers the bus shows the inverse, so a stray sample shows.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			sample_done <= 1'b0;
			sample_error <= 1'b0;
			adc_value <= ~VAL;
		end else begin
			sample_done <= 1'b0;
			sample_error <= 1'b0;
			adc_value <= ~VAL;
			if (sample_req) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
				sample_done <= 1'b1;
				sample_error <= fail;
				adc_value <= VAL;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule : omu_adc_model

// [testbench/omu_top_bench.sv]
// Self-checking bench for the optical monitor update control block.
`timescale 1ns/1ps
`include "omu_defs.svh"

module omu_top_bench;
	logic               ref_clk = 1'b0;
	logic               reset_n = 1'b0;
	logic               mgmt_wr = 1'b0;
	logic               mgmt_rd = 1'b0;
	logic               fail = 1'b0;
	logic [3:0]         lat = 4'h2;
	logic [15:0]        mgmt_addr = 16'h0000;
	logic [15:0]        mgmt_wdata = 16'h0000;
	logic [15:0]        mgmt_rdata;
	logic [15:0]        alarm_flags;
	logic [15:0]        warn_flags;
	logic [15:0]        lai_flags;
	logic               mgmt_rdata_valid;
	logic               sample_req;
	logic               sample_done;
	logic               sample_error;
	omu_pkg::omu_quad_t adc_value;
	omu_pkg::omu_quad_t hi_thr = {4{16'h0064}};
	omu_pkg::omu_quad_t lo_thr = {4{16'h000a}};
	int                 error_cnt = 0;
	int                 compares = 0;

	omu_top #(.SLOW_CYC(40), .MID_CYC(20), .FAST_CYC(10), .TMO_CYC(16)) dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .mgmt_wr(mgmt_wr),
		.mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
		.mgmt_rdata(mgmt_rdata), .mgmt_rdata_valid(mgmt_rdata_valid),
		.sample_req(sample_req), .sample_done(sample_done),
		.sample_error(sample_error), .adc_value(adc_value),
		.alarm_hi_thr(hi_thr), .alarm_lo_thr(lo_thr),
		.warn_hi_thr(hi_thr), .warn_lo_thr(lo_thr),
		.alarm_flags(alarm_flags), .warn_flags(warn_flags),
		.link_alarm_interrupt_flags(lai_flags));

	omu_adc_model adc (
		.ref_clk(ref_clk), .reset_n(reset_n), .sample_req(sample_req),
		.fail(fail), .lat(lat), .sample_done(sample_done),
		.sample_error(sample_error), .adc_value(adc_value));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task conclude;
		$display("mismatches %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	task chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk

	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		mgmt_wr <= 1'b1;
		mgmt_addr <= a;
		mgmt_wdata <= d;
		@(posedge ref_clk);
		mgmt_wr <= 1'b0;
	endtask : wr

	task rd(input logic [15:0] a, input logic [15:0] e);
		int i;
		@(posedge ref_clk);
		mgmt_rd <= 1'b1;
		mgmt_addr <= a;
		@(posedge ref_clk);
		mgmt_rd <= 1'b0;
		@(negedge ref_clk);
		for (i = 0; i < 4 && mgmt_rdata_valid !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 4) begin
			error_cnt++;
			conclude();
		end else begin
			chk(mgmt_rdata, e);
		end
	endtask : rd

	// Waits for the next request pulse; n counts the cycles it took.
	task wreq(output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			if (n > 200) begin
				error_cnt++;
				conclude();
			end
		end while (sample_req !== 1'b1);
	endtask : wreq

	task quiet(output int q);
		q = 0;
		repeat (80) begin
			@(negedge ref_clk);
			if (sample_req === 1'b1)
				q++;
		end
	endtask : quiet

	task t_reset;
		int q;
		rd(`OMU_A_CAP, 16'h00fe);
		rd(`OMU_A_CTRL, 16'h0000);
		rd(16'ha06e, 16'h0000);
		quiet(q);
		chk(16'(q), 16'h0000);
	endtask : t_reset

	task t_single;
		int n;
		lat <= 4'h8;
		wr(`OMU_A_CTRL, 16'h0000);
		wreq(n);
		rd(`OMU_A_CTRL, 16'h0008);
		repeat (16) @(negedge ref_clk);
		rd(`OMU_A_CTRL, 16'h0004);
		rd(16'ha060, 16'h00ff);
		rd(16'ha061, 16'h00fb);
		chk(alarm_flags, 16'h0000);
		lat <= 4'h2;
		wr(`OMU_A_CTRL, 16'h0000);
		wreq(n);
		repeat (8) @(negedge ref_clk);
		chk(alarm_flags, 16'h4840);
		chk(warn_flags, 16'h4840);
		chk(lai_flags, 16'h4840);
		rd(`OMU_A_TXALM, 16'h0048);
		rd(`OMU_A_RXWRN, 16'h0040);
		quiet(n);
		chk(16'(n), 16'h0000);
	endtask : t_single

	task t_periodic;
		int n;
		int g;
		int lim[3];
		lim = '{40, 20, 10};
		for (int c = 1; c < 4; c++) begin
			wr(`OMU_A_CTRL, 16'(c));
			wreq(n);
			wreq(g);
			chk(16'(g >= lim[c-1] && g < lim[c-1] + 16), 16'h0001);
		end
		wr(`OMU_A_CTRL, 16'h0000);
		wreq(n);
		repeat (8) @(negedge ref_clk);
		quiet(n);
		chk(16'(n), 16'h0000);
	endtask : t_periodic

	task t_fail;
		int n;
		fail <= 1'b1;
		wr(`OMU_A_CTRL, 16'h0003);
		wreq(n);
		repeat (8) @(negedge ref_clk);
		rd(`OMU_A_CTRL, 16'h000f);
		quiet(n);
		chk(16'(n), 16'h0000);
		fail <= 1'b0;
		// A converter slower than the timeout must count as a failure.
		lat <= 4'hf;
		wr(`OMU_A_CTRL, 16'h0002);
		wreq(n);
		repeat (24) @(negedge ref_clk);
		rd(`OMU_A_CTRL, 16'h000e);
		chk(alarm_flags, 16'h4840);
		quiet(n);
		chk(16'(n), 16'h0000);
		lat <= 4'h2;
	endtask : t_fail

	task t_midreset;
		int n;
		wr(`OMU_A_CTRL, 16'h0003);
		wreq(n);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(`OMU_A_CTRL, 16'h0000);
		chk(alarm_flags, 16'h0000);
		chk(lai_flags, 16'h0000);
		quiet(n);
		chk(16'(n), 16'h0000);
	endtask : t_midreset

	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_single();
		t_periodic();
		t_fail();
		t_midreset();
		conclude();
	end
endmodule : omu_top_bench
